// file: hw/lts_pkg.sv
package lts_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] HITCNT_OFF = 8'h04;
	localparam logic [7:0] MISSCNT_OFF = 8'h08;
	// Control register field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_DO_BIT = 1;
	localparam int CTRL_TS_BIT = 2;
	localparam int CTRL_GI_BIT = 3;
	localparam int CTRL_TYPE_LSB = 4;
	localparam int CTRL_SIZE_LSB = 6;
	localparam int CTRL_IP_BIT = 8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Storage attributes forced while translation is off
	localparam logic [3:0] DEFAULT_ATTR = 4'h3;
	// Geometry: 32-byte lines, two ways, index grows with cache size
	localparam int LINE_BYTES = 32;
	localparam int LINE_WORDS = LINE_BYTES / 4;
	localparam int OFFSET_BITS = 5;
	localparam int SET_W = 14;
	localparam int TAG_W = 15;
	localparam int TAG_BITS_256K = 15;
	localparam int TAG_BITS_512K = 14;
	localparam int TAG_BITS_1M = 13;
	localparam int MAX_SETS = 16384;
	localparam int SRAM_AW = 1 + SET_W + 3;
	// Sequencer: one way entry per core clock, about 32K clocks in all
	localparam int INV_STEPS_DEFAULT = 2 * MAX_SETS;
	// SRAM read latencies in clocks, plus pin synchroniser depth
	localparam logic [3:0] LAT_FLOW = 4'h1;
	localparam logic [3:0] LAT_PIPE = 4'h2;
	localparam logic [3:0] LAT_LATE = 4'h2;
	localparam logic [3:0] LAT_PIPE3_EXTRA = 4'h1;
	localparam logic [3:0] SYNC_STAGES = 4'h2;
	// SRAM flavour and cache size codes
	typedef enum logic [1:0] {SRAM_FLOW, SRAM_PIPE2, SRAM_LATEWR, SRAM_PIPE3} lts_sram_kind_t;
	typedef enum logic [1:0] {SZ_256K, SZ_512K, SZ_1M, SZ_RSVD} lts_size_t;
	// AXI4-Lite master to slave
	typedef struct packed {
		logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata;
		logic [3:0] wstrb; logic bready; logic arvalid; logic [31:0] araddr; logic rready;
	} lts_axi_req_t;
	// AXI4-Lite slave to master
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} lts_axi_rsp_t;
	// Load/store/fetch request from the core
	typedef struct packed {
		logic valid; logic fetch; logic write; logic l1dOn; logic translate;
		logic [3:0] attr; logic [31:0] addr; logic [31:0] wdata;
	} lts_core_req_t;
	// Answer to the core
	typedef struct packed {
		logic valid; logic hit; logic single; logic [3:0] attr; logic [31:0] rdata;
	} lts_core_rsp_t;
	// Modified L1 line pushed into the cache
	typedef struct packed {
		logic valid; logic [31:0] addr; logic [LINE_BYTES*8-1:0] line;
	} lts_push_t;
	// External SRAM command
	typedef struct packed {
		logic en; logic we; logic [SRAM_AW-1:0] addr; logic [31:0] wdata;
	} lts_sram_out_t;
	// Tag array entry
	typedef struct packed {
		logic valid; logic [TAG_W-1:0] tag;
	} lts_tag_t;
endpackage

// file: hw/lts_l2_test_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// - Tag holds 15/14/13 bits per size
// - Translation off forces attributes 0b0011
// - Data-only mode still lets fetches hit
// - Test support, L1D off: single-beat, uncounted misses
// - Miss event counts only burst-read misses
// - L1D off single-beat hits counted as hits
// - Two ways per set
// - Push writes whole 32-byte line
// - Tag mismatch in both ways misses
// - Clearing test bits restores normal operation
// - Supports flow, pipelined, late-write, three-stage SRAM
// - Three-stage SRAM has own config code
// - Three-stage SRAM adds one read wait
// - Sequencer clears all tags, status, replacement
// - In-progress flag stays set during sequence
module lts_l2_test_ctrl #(
	parameter int INV_STEPS = lts_pkg::INV_STEPS_DEFAULT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register bus
	input wire lts_pkg::lts_axi_req_t axiReq,
	output lts_pkg::lts_axi_rsp_t axiRsp,
	// Core access path
	input wire lts_pkg::lts_core_req_t coreReq,
	output logic coreReady,
	output lts_pkg::lts_core_rsp_t coreRsp,
	// L1 line push path
	input wire lts_pkg::lts_push_t pushReq,
	output logic pushReady,
	// External SRAM
	output lts_pkg::lts_sram_out_t sramOut,
	input wire logic [31:0] sramRdata
);
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PUSH, ST_INVAL} lts_state_t;

	// Tag array, two ways side by side, and one replacement bit per set
	lts_pkg::lts_tag_t tagMem [0:2*lts_pkg::MAX_SETS-1];
	logic replMem [0:lts_pkg::MAX_SETS-1];

	// Control, counters and sequencing state
	logic [7:0] ctrl_q, ctrl_d;
	logic [31:0] hitCnt_q, hitCnt_d, missCnt_q, missCnt_d;
	lts_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic giPrev_q, giPrev_d;
	logic [lts_pkg::SRAM_AW-1:0] base_q, base_d;
	logic [lts_pkg::LINE_BYTES*8-1:0] line_q, line_d;
	lts_pkg::lts_core_rsp_t rsp_q, rsp_d;
	lts_pkg::lts_sram_out_t sram_q, sram_d;
	// Bus slave state
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
	logic wStrb0_q, wStrb0_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	// Read data pin synchroniser
	logic [31:0] rdSync1_q, rdSync2_q;
	// Array write ports
	logic tagWe, replWe, replWData;
	logic [lts_pkg::SET_W:0] tagWAddr;
	logic [lts_pkg::SET_W-1:0] replWAddr;
	lts_pkg::lts_tag_t tagWData;
	// Lookup results
	logic [lts_pkg::SET_W-1:0] reqIdx, pushIdx;
	logic [lts_pkg::TAG_W-1:0] reqTag, pushTag;
	logic [1:0] wayHit;
	logic anyHit, hitWay, accept, pushStart, invStart, readStart, cntClr;
	logic [1:0] pushHit;
	logic [3:0] readWait;

	// Index of an address; the index widens as the cache grows
	function automatic logic [lts_pkg::SET_W-1:0] idxOf(logic [31:0] a, logic [1:0] sz);
		case (sz)
			lts_pkg::SZ_256K: idxOf = {2'h0, a[16:5]};
			lts_pkg::SZ_512K: idxOf = {1'h0, a[17:5]};
			default: idxOf = a[18:5];
		endcase
	endfunction
	// Tag of an address: 15, 14 or 13 upper bits, zero filled
	function automatic logic [lts_pkg::TAG_W-1:0] tagOf(logic [31:0] a, logic [1:0] sz);
		case (sz)
			lts_pkg::SZ_256K: tagOf = a[31:17];
			lts_pkg::SZ_512K: tagOf = {1'h0, a[31:18]};
			default: tagOf = {2'h0, a[31:19]};
		endcase
	endfunction

	// SRAM flavour field of the control register
	function automatic logic [1:0] lts_lts_kind(logic [7:0] c);
		lts_lts_kind = c[lts_pkg::CTRL_TYPE_LSB +: 2];
	endfunction

	// Read latency per SRAM flavour, pins then synchroniser
	always_comb
	begin
		case (lts_lts_kind(ctrl_q))
			lts_pkg::SRAM_FLOW: readWait = lts_pkg::LAT_FLOW + lts_pkg::SYNC_STAGES;
			lts_pkg::SRAM_PIPE2: readWait = lts_pkg::LAT_PIPE + lts_pkg::SYNC_STAGES;
			lts_pkg::SRAM_LATEWR: readWait = lts_pkg::LAT_LATE + lts_pkg::SYNC_STAGES;
			// Array access spans two clocks, so one more wait
			default: readWait = lts_pkg::LAT_PIPE + lts_pkg::LAT_PIPE3_EXTRA
				+ lts_pkg::SYNC_STAGES;
		endcase
	end

	// Two-way lookup; a tag differing in both ways cannot hit
	always_comb
	begin
		reqIdx = idxOf(coreReq.addr, ctrl_q[lts_pkg::CTRL_SIZE_LSB +: 2]);
		reqTag = tagOf(coreReq.addr, ctrl_q[lts_pkg::CTRL_SIZE_LSB +: 2]);
		pushIdx = idxOf(pushReq.addr, ctrl_q[lts_pkg::CTRL_SIZE_LSB +: 2]);
		pushTag = tagOf(pushReq.addr, ctrl_q[lts_pkg::CTRL_SIZE_LSB +: 2]);
		for (int w = 0; w < 2; w++)
		begin
			wayHit[w] = tagMem[{reqIdx, w[0]}].valid && tagMem[{reqIdx, w[0]}].tag == reqTag;
			pushHit[w] = tagMem[{pushIdx, w[0]}].valid && tagMem[{pushIdx, w[0]}].tag == pushTag;
		end
		anyHit = |wayHit;
		hitWay = wayHit[1];
	end

	// Handshakes: sequencer first, then line push, then core access
	assign invStart = state_q == ST_IDLE && ctrl_q[lts_pkg::CTRL_GI_BIT] && !giPrev_q;
	assign pushReady = state_q == ST_IDLE && !invStart;
	assign pushStart = pushReady && pushReq.valid;
	assign coreReady = pushReady && !pushReq.valid;
	assign accept = coreReady && coreReq.valid;
	assign readStart = accept && ctrl_q[lts_pkg::CTRL_EN_BIT] && anyHit && !coreReq.write;
	assign cntClr = bvalid_d && !bvalid_q && bresp_d == lts_pkg::RESP_OKAY;

	// Bus slave and register next values
	always_comb
	begin
		awHeld_d = awHeld_q;
		awAddr_d = awAddr_q;
		wHeld_d = wHeld_q;
		wData_d = wData_q;
		wStrb0_d = wStrb0_q;
		bvalid_d = bvalid_q && !axiReq.bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !axiReq.rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		axiRsp.awready = !awHeld_q && !bvalid_q;
		axiRsp.wready = !wHeld_q && !bvalid_q;
		axiRsp.arready = !rvalid_q;
		if (axiReq.awvalid && axiRsp.awready)
		begin
			awHeld_d = 1'b1;
			awAddr_d = axiReq.awaddr[7:0];
		end
		if (axiReq.wvalid && axiRsp.wready)
		begin
			wHeld_d = 1'b1;
			wData_d = axiReq.wdata;
			wStrb0_d = axiReq.wstrb[0];
		end
		// Address and data in either order; answer once both are held
		if (awHeld_q && wHeld_q && !bvalid_q)
		begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = lts_pkg::RESP_OKAY;
			if (awAddr_q == lts_pkg::CTRL_OFF)
			begin
				// Byte 0 holds every writable bit; other lanes leave it alone
				if (wStrb0_q)
					ctrl_d = wData_q[7:0];
			end
			else if (awAddr_q != lts_pkg::HITCNT_OFF && awAddr_q != lts_pkg::MISSCNT_OFF)
				bresp_d = lts_pkg::RESP_SLVERR;
		end
		if (axiReq.arvalid && axiRsp.arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = lts_pkg::RESP_OKAY;
			case (axiReq.araddr[7:0])
				lts_pkg::CTRL_OFF: rdata_d = {23'h0, state_q == ST_INVAL, ctrl_q};
				lts_pkg::HITCNT_OFF: rdata_d = hitCnt_q;
				lts_pkg::MISSCNT_OFF: rdata_d = missCnt_q;
				default:
				begin
					rdata_d = 32'h0;
					rresp_d = lts_pkg::RESP_SLVERR;
				end
			endcase
		end
		axiRsp.bvalid = bvalid_q;
		axiRsp.bresp = bresp_q;
		axiRsp.rvalid = rvalid_q;
		axiRsp.rdata = rdata_q;
		axiRsp.rresp = rresp_q;
	end

	// Cache sequencing next values
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		base_d = base_q;
		line_d = line_q;
		giPrev_d = ctrl_q[lts_pkg::CTRL_GI_BIT];
		rsp_d = rsp_q;
		rsp_d.valid = 1'b0;
		sram_d = sram_q;
		sram_d.en = 1'b0;
		sram_d.we = 1'b0;
		// Writing a counter clears it, but a counted event in that cycle survives
		hitCnt_d = (cntClr && awAddr_q == lts_pkg::HITCNT_OFF) ? 32'h0 : hitCnt_q;
		missCnt_d = (cntClr && awAddr_q == lts_pkg::MISSCNT_OFF) ? 32'h0 : missCnt_q;
		tagWe = 1'b0;
		tagWAddr = '0;
		tagWData = '0;
		replWe = 1'b0;
		replWAddr = '0;
		replWData = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (invStart)
				begin
					state_d = ST_INVAL;
					cnt_d = 16'h0;
				end
				else if (pushStart)
				begin
					// Reuse the way already holding the line, else the older way
					// Replacement bit names the victim way of the set
					base_d = {pushHit[1] | (!pushHit[0] & replMem[pushIdx]), pushIdx, 3'h0};
					line_d = pushReq.line;
					tagWe = 1'b1;
					// Tag entries sit set first, way in the lowest bit
					tagWAddr = {pushIdx, base_d[lts_pkg::SRAM_AW-1]};
					tagWData = '{valid: 1'b1, tag: pushTag};
					replWe = 1'b1;
					replWAddr = pushIdx;
					replWData = !base_d[lts_pkg::SRAM_AW-1];
					cnt_d = 16'h0;
					state_d = ST_PUSH;
				end
				else if (accept)
				begin
					rsp_d.attr = coreReq.translate ? coreReq.attr : lts_pkg::DEFAULT_ATTR;
					rsp_d.single = !coreReq.l1dOn;
					rsp_d.hit = ctrl_q[lts_pkg::CTRL_EN_BIT] && anyHit;
					rsp_d.rdata = 32'h0;
					base_d = {hitWay, reqIdx, coreReq.addr[4:2]};
					if (rsp_d.hit)
					begin
						// Fetches hit too, even in data-only mode
						hitCnt_d = hitCnt_d + 32'h1;
						replWe = 1'b1;
						replWAddr = reqIdx;
						replWData = !hitWay;
						sram_d = '{en: 1'b1, we: coreReq.write, addr: base_d, wdata: coreReq.wdata};
						if (coreReq.write)
							rsp_d.valid = 1'b1;
						else
						begin
							cnt_d = {12'h0, readWait};
							state_d = ST_READ;
						end
					end
					else
					begin
						rsp_d.valid = 1'b1;
						// Only burst reads count as misses; single beats never do
						if (ctrl_q[lts_pkg::CTRL_EN_BIT] && coreReq.l1dOn && !coreReq.write)
							missCnt_d = missCnt_d + 32'h1;
					end
				end
			end
			ST_READ:
			begin
				if (cnt_q == 16'h0)
				begin
					rsp_d.valid = 1'b1;
					rsp_d.rdata = rdSync2_q;
					state_d = ST_IDLE;
				end
				else
					cnt_d = cnt_q - 16'h1;
			end
			ST_PUSH:
			begin
				// One word per clock, whole line, straight into the SRAM
				sram_d.en = 1'b1;
				sram_d.we = 1'b1;
				sram_d.addr = {base_q[lts_pkg::SRAM_AW-1:3], cnt_q[2:0]};
				sram_d.wdata = line_q[cnt_q[2:0]*32 +: 32];
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == 16'(lts_pkg::LINE_WORDS - 1))
					state_d = ST_IDLE;
			end
			ST_INVAL:
			begin
				// One way entry per clock; replacement bit cleared with way 0
				tagWe = 1'b1;
				tagWAddr = cnt_q[lts_pkg::SET_W:0];
				replWe = !cnt_q[0];
				replWAddr = cnt_q[lts_pkg::SET_W:1];
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == 16'(INV_STEPS - 1))
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// Tag and replacement arrays carry no reset; the sequencer clears them
	always_ff @(posedge sys_clk)
	begin
		if (tagWe)
			tagMem[tagWAddr] <= tagWData;
		if (replWe)
			replMem[replWAddr] <= replWData;
	end

	// Read data arrives from pins: two flops before use
	always_ff @(posedge sys_clk)
	begin
		rdSync1_q <= sramRdata;
		rdSync2_q <= rdSync1_q;
	end

	// State registers
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_q <= lts_pkg::CTRL_RESET;
			hitCnt_q <= 32'h0;
			missCnt_q <= 32'h0;
			state_q <= ST_IDLE;
			cnt_q <= 16'h0;
			giPrev_q <= 1'b0;
			base_q <= '0;
			line_q <= '0;
			rsp_q <= '0;
			sram_q <= '0;
			awHeld_q <= 1'b0;
			awAddr_q <= 8'h0;
			wHeld_q <= 1'b0;
			wData_q <= 32'h0;
			wStrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			hitCnt_q <= hitCnt_d;
			missCnt_q <= missCnt_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			giPrev_q <= giPrev_d;
			base_q <= base_d;
			line_q <= line_d;
			rsp_q <= rsp_d;
			sram_q <= sram_d;
			awHeld_q <= awHeld_d;
			awAddr_q <= awAddr_d;
			wHeld_q <= wHeld_d;
			wData_q <= wData_d;
			wStrb0_q <= wStrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign coreRsp = rsp_q;
	assign sramOut = sram_q;

	// Checks on the block's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	int unsigned invLast = INV_STEPS - 1;
	inval_start_a: assert property (invStart |=> state_q == ST_INVAL)
		else $error("invalidate did not start");
	inval_end_a: assert property (state_q == ST_INVAL && cnt_q == invLast |=> state_q == ST_IDLE)
		else $error("invalidate did not finish");
	attr_default_a: assert property (accept && !coreReq.translate |=> coreRsp.attr == 4'h3)
		else $error("default attributes not applied");
	single_nomiss_a: assert property (accept && !coreReq.l1dOn && !cntClr |=> $stable(missCnt_q))
		else $error("single-beat access counted as miss");
	burst_miss_a: assert property (accept && coreReq.l1dOn && !coreReq.write && !anyHit
		&& ctrl_q[0] && !cntClr |=> missCnt_q == $past(missCnt_q) + 32'h1)
		else $error("burst miss not counted");
	hit_count_a: assert property (accept && anyHit && ctrl_q[0] && !cntClr
		|=> hitCnt_q == $past(hitCnt_q) + 32'h1)
		else $error("hit not counted");
	fetch_hit_a: assert property (readStart && coreReq.fetch |=> state_q == ST_READ
		##[4:6] coreRsp.valid && coreRsp.hit)
		else $error("fetch failed to hit");
	miss_tag_a: assert property (accept && !anyHit |=> coreRsp.valid && !coreRsp.hit)
		else $error("mismatching tag hit");
	pipe3_wait_a: assert property (readStart && ctrl_q[5:4] == 2'h3 |-> ##7 coreRsp.valid)
		else $error("three-stage read wait wrong");
	pipe2_wait_a: assert property (readStart && ctrl_q[5:4] == 2'h1 |-> ##6 coreRsp.valid)
		else $error("pipelined read wait wrong");
	push_line_a: assert property (pushStart |-> ##2 sramOut.we [*8] ##1 !sramOut.we)
		else $error("push did not write eight words");
	cover_inval_c: cover property (invStart ##1 state_q == ST_INVAL);
	cover_push_c: cover property (pushStart);
	cover_hit_c: cover property (readStart && ctrl_q[1] && coreReq.fetch);
	cover_single_c: cover property (accept && anyHit && !coreReq.l1dOn);
endmodule // lts_l2_test_ctrl

// file: tb/lts_sram_model.sv
`timescale 1ns/1ns
// Behavioural burst SRAM standing behind the cache pins
module lts_sram_model (
	// Clock
	input wire logic sys_clk,
	// Command from the cache and flavour in use
	input wire lts_pkg::lts_sram_out_t sramOut,
	input wire logic [1:0] kind,
	// Read data pins
	output logic [31:0] sramRdata
);
	logic [31:0] mem [int]; // Sparse, only written words are read back
	logic [31:0] pend; // Word waiting for its beat
	int cnt; // Edges left before the beat
	int lat; // Read latency of the flavour
	// Three-stage parts stage the array access over two cycles
	assign lat = (kind == 2'h0) ? 1 : (kind == 2'h3) ? 3 : 2;
	initial
	begin
		sramRdata = 32'h0;
		cnt = 0;
	end
	// Writes land at once, there is no internal write queue
	always @(posedge sys_clk)
	begin
		// A beat lasts one cycle; between beats the pins show junk
		if (cnt == 1)
			sramRdata <= pend;
		else
			sramRdata <= ~sramRdata;
		if (cnt != 0)
			cnt <= cnt - 1;
		if (sramOut.en && sramOut.we)
			mem[int'(sramOut.addr)] = sramOut.wdata;
		if (sramOut.en && !sramOut.we)
		begin
			// Flow parts drive the word at once; other flavours flip the pins to the inverse each edge until the beat arrives
			sramRdata <= (lat == 1) ? mem[int'(sramOut.addr)] : ~sramRdata;
			pend <= mem[int'(sramOut.addr)];
			cnt <= lat - 1;
		end
	end
endmodule // lts_sram_model

// file: tb/tb_lts_l2_test_ctrl.sv
`timescale 1ns/1ns
// Registers over AXI4-Lite, core accesses, line pushes, SRAM model
module tb_lts_l2_test_ctrl;
	localparam int INV = 16400; // Sweep covers every entry touched below
	localparam logic [31:0] EN = 32'h1 << lts_pkg::CTRL_EN_BIT;
	localparam logic [31:0] DO = 32'h1 << lts_pkg::CTRL_DO_BIT;
	localparam logic [31:0] TS = 32'h1 << lts_pkg::CTRL_TS_BIT;
	localparam logic [31:0] GI = 32'h1 << lts_pkg::CTRL_GI_BIT;
	localparam logic [31:0] IP = 32'h1 << lts_pkg::CTRL_IP_BIT;
	localparam logic [1:0] OK = lts_pkg::RESP_OKAY;
	logic sys_clk;
	logic reset;
	lts_pkg::lts_axi_req_t axiReq;
	lts_pkg::lts_axi_rsp_t axiRsp;
	lts_pkg::lts_core_req_t coreReq;
	logic coreReady;
	lts_pkg::lts_core_rsp_t coreRsp;
	lts_pkg::lts_push_t pushReq;
	logic pushReady;
	lts_pkg::lts_sram_out_t sramOut;
	logic [31:0] sramRdata;
	logic [1:0] kind; // SRAM flavour of this pass
	int err_total;
	int compares;
	int seed;
	int hits; // Hits the counter should show
	int misses; // Burst misses the counter should show
	int tl; // Lowest tag bit for the size in use
	logic [38:0] coreQ [$]; // Check data, hit, single, attr, data
	logic [33:0] rdQ [$]; // Response and read data
	logic [1:0] bQ [$]; // Write responses
	logic [38:0] ce;
	logic [255:0] ln [4]; // Lines pushed in this pass
	logic [31:0] base [4];
	logic [31:0] ctl;
	logic [31:0] sd;

	lts_l2_test_ctrl #(.INV_STEPS(INV)) lts_l2_test_ctrl_i (.sys_clk(sys_clk), .reset(reset),
		.axiReq(axiReq), .axiRsp(axiRsp), .coreReq(coreReq), .coreReady(coreReady),
		.coreRsp(coreRsp), .pushReq(pushReq), .pushReady(pushReady), .sramOut(sramOut),
		.sramRdata(sramRdata));
	lts_sram_model lts_sram_model_i (.sys_clk(sys_clk), .sramOut(sramOut), .kind(kind),
		.sramRdata(sramRdata));

	// Clock at 250 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever
			#2 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Write; address and data may be taken on different edges
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bQ.push_back(r);
		@(posedge sys_clk);
		axiReq <= '{awvalid:1'b1, awaddr:32'(a), wvalid:1'b1, wdata:d, wstrb:s, bready:1'b1,
			default:'0};
		forever
		begin
			@(posedge sys_clk);
			if (axiRsp.awready)
				axiReq.awvalid <= 1'b0;
			if (axiRsp.wready)
				axiReq.wvalid <= 1'b0;
			if (axiRsp.bvalid)
				break;
		end
		axiReq.bready <= 1'b0;
	endtask

	// Read; the answer is matched by the watcher
	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		rdQ.push_back(e);
		@(posedge sys_clk);
		axiReq <= '{arvalid:1'b1, araddr:32'(a), rready:1'b1, default:'0};
		forever
		begin
			@(posedge sys_clk);
			if (axiRsp.arready)
				axiReq.arvalid <= 1'b0;
			if (axiRsp.rvalid)
				break;
		end
		axiReq.rready <= 1'b0;
	endtask

	// Core access, translation on or off at random; data compared on load hits only
	task automatic acc(input logic f, input logic w, input logic l1, input logic [31:0] a,
		input logic [31:0] d, input logic h);
		logic tr;
		logic [3:0] at;
		tr = 1'($random(seed));
		at = 4'($random(seed));
		coreQ.push_back({h && !w, h, !l1, tr ? at : lts_pkg::DEFAULT_ATTR, d});
		if (h)
			hits++;
		else if (l1 && !w)
			misses++;
		@(posedge sys_clk);
		coreReq <= '{valid:1'b1, fetch:f, write:w, l1dOn:l1, translate:tr,
			attr:at, addr:a, wdata:d};
		do
			@(posedge sys_clk);
		while (!coreReady);
		coreReq.valid <= 1'b0;
		while (coreQ.size() != 0)
			@(posedge sys_clk);
	endtask

	// Modified L1 line into the cache
	task automatic push(input logic [31:0] a, input logic [255:0] l);
		@(posedge sys_clk);
		pushReq <= '{valid:1'b1, addr:a, line:l};
		do
			@(posedge sys_clk);
		while (!pushReady);
		pushReq.valid <= 1'b0;
		repeat (10) @(posedge sys_clk); // Eight beats still leaving
	endtask

	// One pass per SRAM flavour, cache size code equal to it
	task automatic pass(input int i);
		kind <= 2'(i);
		tl = 17 + ((i > 2) ? 2 : i);
		ctl = (32'(i) << lts_pkg::CTRL_TYPE_LSB) | (32'(i) << lts_pkg::CTRL_SIZE_LSB);
		// Sweep with the cache off; flag must cover the whole sweep only
		axw(lts_pkg::CTRL_OFF, ctl | GI, 4'hf, OK);
		axr(lts_pkg::CTRL_OFF, {OK, ctl | GI | IP});
		repeat (INV - 60) @(posedge sys_clk);
		axr(lts_pkg::CTRL_OFF, {OK, ctl | GI | IP});
		repeat (100) @(posedge sys_clk);
		axr(lts_pkg::CTRL_OFF, {OK, ctl | GI});
		axw(lts_pkg::CTRL_OFF, ctl | EN | DO | TS, 4'hf, OK);
		axr(lts_pkg::CTRL_OFF, {OK, ctl | EN | DO | TS});
		axw(lts_pkg::HITCNT_OFF, 32'h0, 4'hf, OK);
		axw(lts_pkg::MISSCNT_OFF, 32'h0, 4'hf, OK);
		hits = 0;
		misses = 0;
		// A, C, D share set 0 only if the tag width is right
		base = '{32'h0, 32'h1 << (tl - 1), 32'h1 << tl, 32'h1 << (tl + 1)};
		for (int j = 0; j < 4; j++)
		begin
			for (int k = 0; k < 8; k++)
				ln[j][32*k +: 32] = $random(seed);
			push(base[j], ln[j]);
		end
		acc(1'b0, 1'b0, 1'b1, base[0], 32'h0, 1'b0);
		for (int k = 0; k < 8; k++)
			acc(1'b0, 1'b0, 1'b0, base[1] + 32'(4 * k), ln[1][32*k +: 32], 1'b1);
		acc(1'b1, 1'b0, 1'b0, base[2] + 32'h8, ln[2][64 +: 32], 1'b1);
		sd = $random(seed);
		acc(1'b0, 1'b1, 1'b0, base[3] + 32'hc, sd, 1'b1);
		acc(1'b0, 1'b0, 1'b0, base[3] + 32'hc, sd, 1'b1);
		for (int b = tl; b < 32; b++)
			acc(1'b0, 1'b0, 1'b0, base[1] | (32'h1 << b), 32'h0, 1'b0);
		axr(lts_pkg::HITCNT_OFF, {OK, 32'(hits)});
		axr(lts_pkg::MISSCNT_OFF, {OK, 32'(misses)});
		// Test bits off: burst accesses and counted misses again
		axw(lts_pkg::CTRL_OFF, ctl | EN, 4'hf, OK);
		acc(1'b0, 1'b0, 1'b1, base[2], ln[2][31:0], 1'b1);
		acc(1'b0, 1'b0, 1'b1, base[1] | 32'h8000_0000, 32'h0, 1'b0);
		axr(lts_pkg::HITCNT_OFF, {OK, 32'(hits)});
		axr(lts_pkg::MISSCNT_OFF, {OK, 32'(misses)});
	endtask

	// Results are matched against the oldest note as they appear
	always @(posedge sys_clk)
	begin
		if (coreRsp.valid)
		begin
			ce = coreQ.pop_front();
			check({coreRsp.hit, coreRsp.single, coreRsp.attr}, ce[37:32]);
			if (ce[38])
				check(coreRsp.rdata, ce[31:0]);
		end
		if (axiRsp.rvalid && axiReq.rready)
			check({axiRsp.rresp, axiRsp.rdata}, rdQ.pop_front());
		if (axiRsp.bvalid && axiReq.bready)
			check(axiRsp.bresp, bQ.pop_front());
	end

	// Hang guard, sized above four sweeps plus traffic
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		close_out();
	end

	initial
	begin
		seed = 85;
		err_total = 0;
		compares = 0;
		hits = 0;
		misses = 0;
		kind = 2'h0;
		reset = 1'b1;
		axiReq = '0;
		coreReq = '0;
		pushReq = '0;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		// Strobe without byte 0 leaves control alone; a hole answers an error
		axw(lts_pkg::CTRL_OFF, 32'hff, 4'he, OK);
		axr(lts_pkg::CTRL_OFF, {OK, 32'h0});
		axw(8'h0c, 32'h1, 4'hf, lts_pkg::RESP_SLVERR);
		axr(8'h0c, {lts_pkg::RESP_SLVERR, 32'h0});
		for (int i = 0; i < 4; i++)
			pass(i);
		close_out();
	end
endmodule // tb_lts_l2_test_ctrl
